/* File: bench/mrw_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the byte link between master and slave
module mrw_properties (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic q_valid_i,
	input wire logic [7:0] q_data_i,
	input wire logic q_last_i,
	input wire logic r_valid_i,
	input wire logic [7:0] r_data_i,
	input wire logic r_last_i
);
	logic [7:0] qb_q [8];
	logic [2:0] qn_q;
	logic [7:0] rn_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	// last query frame and index of the reply byte
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			qn_q <= 3'h0;
			rn_q <= 8'h00;
		end else begin
			if (q_valid_i) begin
				qb_q[qn_q] <= q_data_i;
				qn_q <= q_last_i ? 3'h0 : qn_q + 3'h1;
			end
			if (r_valid_i) begin
				rn_q <= r_last_i ? 8'h00 : rn_q + 8'h01;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	AST_Q_LEN: assert property (
		q_last_i |-> q_valid_i && qn_q == 3'h7)
		else $error("query frame not eight bytes");
	// last query byte sampled, evaluation, first reply state, reply byte sampled
	AST_R_FIRST: assert property (
		r_valid_i && rn_q == 8'h00 |-> $past(q_last_i, 3) && r_data_i == qb_q[0])
		else $error("reply start wrong");
	AST_NO_BCAST: assert property (
		r_valid_i |-> qb_q[0] != mrw_pkg::BCAST_ADDR)
		else $error("reply to broadcast");
	AST_FUNC: assert property (
		r_valid_i && rn_q == 8'h01 |-> r_data_i == qb_q[1])
		else $error("reply function byte wrong");
	AST_ECHO: assert property (
		r_valid_i && qb_q[1] == mrw_pkg::FC_WRITE
		|-> r_data_i == qb_q[rn_q[2:0]] && r_last_i == (rn_q == 8'h07))
		else $error("write echo differs");
	AST_BYTE_CNT: assert property (
		r_valid_i && rn_q == 8'h02 && qb_q[1] == mrw_pkg::FC_READ
		|-> r_data_i == {qb_q[5][6:0], 1'b0})
		else $error("byte count wrong");
	AST_READ_LEN: assert property (
		r_last_i && qb_q[1] == mrw_pkg::FC_READ |-> rn_q == {qb_q[5][6:0], 1'b0} + 8'h04)
		else $error("read reply length wrong");
	AST_R_GAP: assert property (
		r_valid_i && !r_last_i |-> ##[1:2] r_valid_i)
		else $error("reply stalls mid frame");
endmodule : mrw_properties
`default_nettype wire

/* File: bench/tb_modbus_rtu_register_read_write.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_rtu_register_read_write;
	localparam int PROC = 4;
	logic clk = 1'b0;
	logic rst_n, rd, wr, drop, allow, cv, crdy, cw, wv, done, ok;
	logic [7:0] own, cs, cc;
	logic [15:0] addr, wdat, rdat, cn, cd, w;
	logic [15:0] mem [32];
	logic [7:0] qq[$], rq[$];
	logic [15:0] wq[$];
	int drops, rds, err_total, checked;
	// clock and the two ends facing each other
	always #25 clk = ~clk;
	mrw_link_if link ();
	mrw_slave mrw_slave_i (.core_clk_i(clk), .rst_n_i(rst_n), .link(link), .own_addr_i(own),
		.reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdat),
		.reg_rdata_i(rdat), .reg_wr_allow_i(allow), .drop_o(drop));
	mrw_master #(.PROC_CYC(PROC), .TIMEOUT_CYC(50)) mrw_master_i (.core_clk_i(clk),
		.rst_n_i(rst_n), .link(link), .cmd_valid_i(cv), .cmd_ready_o(crdy), .cmd_write_i(cw),
		.cmd_slave_i(cs), .cmd_reg_num_i(cn), .cmd_count_i(cc), .cmd_wdata_i(cd),
		.rsp_word_valid_o(wv), .rsp_word_o(w), .rsp_done_o(done), .rsp_ok_o(ok));
	mrw_properties mrw_properties_i (.core_clk_i(clk), .rst_n_i(rst_n), .q_valid_i(link.q_valid),
		.q_data_i(link.q_data), .q_last_i(link.q_last), .r_valid_i(link.r_valid),
		.r_data_i(link.r_data), .r_last_i(link.r_last));
	////////////////////////////////////////////////////////////////////////////////
	// register model, field bit 8 marks the locked area
	assign rdat = mem[{addr[8], addr[3:0]}];
	assign allow = !addr[8];
	always @(posedge clk) begin
		if (wr) mem[{addr[8], addr[3:0]}] <= wdat;
		if (link.q_valid) qq.push_back(link.q_data);
		if (link.r_valid) rq.push_back(link.r_data);
		if (wv) wq.push_back(w);
		if (drop) drops++;
		if (rd) rds++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkq(input logic [7:0] got[$], input logic [7:0] exp[$]);
		chk(16'(got.size()), 16'(exp.size()));
		foreach (exp[i]) chk({8'h00, got[i]}, {8'h00, exp[i]});
	endtask : chkq
	// one command through the master, bounded wait for done
	task automatic cmd(input logic wrt, input logic [7:0] sl, input logic [15:0] num,
		input logic [7:0] cnt, input logic [15:0] dat, output int cyc);
		qq = {};
		rq = {};
		wq = {};
		drops = 0;
		rds = 0;
		cyc = 0;
		@(negedge clk);
		chk({15'h0000, crdy}, 16'h0001);
		cv = 1'b1;
		cw = wrt;
		cs = sl;
		cn = num;
		cc = cnt;
		cd = dat;
		@(negedge clk);
		cv = 1'b0;
		while (done !== 1'b1 && cyc < 400) begin
			@(negedge clk);
			cyc++;
		end
		// a command that never finishes counts as a mismatch
		chk({15'h0000, done}, 16'h0001);
	endtask : cmd
	task automatic final_report();
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	// watchdog
	initial begin
		#500us;
		err_total++;
		final_report();
	end
	// test sequence
	initial begin
		int c;
		logic [15:0] bad [3];
		bad = '{16'h0001, 16'h0500, 16'h057E};
		rst_n = 1'b0;
		own = 8'h11;
		cv = 1'b0;
		cw = 1'b0;
		cs = 8'h00;
		cn = 16'h0000;
		cc = 8'h00;
		cd = 16'h0000;
		foreach (mem[i]) mem[i] = 16'(i * 257);
		mem[27] = 16'h1770;
		mem[28] = 16'h0BB8;
		mem[29] = 16'h03E8;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		// three registers, known frames
		cmd(1'b0, 8'h11, 16'd41004, 8'h03, 16'h0000, c);
		chkq(qq, {8'h11, 8'h03, 8'h03, 8'hEB, 8'h00, 8'h03, 8'h77, 8'h2B});
		chkq(rq, {8'h11, 8'h03, 8'h06, 8'h17, 8'h70, 8'h0B, 8'hB8, 8'h03, 8'hE8, 8'h2C, 8'hE6});
		for (int i = 0; i < 3; i++) chk(wq[i], mem[27 + i]);
		chk(16'(rds), 16'h0003);
		chk(16'(ok), 16'h0001);
		// addressed write and echo
		own = 8'h05;
		cmd(1'b1, 8'h05, 16'd40014, 8'h01, 16'h1770, c);
		chkq(qq, {8'h05, 8'h06, 8'h00, 8'h0D, 8'h17, 8'h70, 8'h17, 8'h99});
		chkq(rq, qq);
		chk(mem[13], 16'h1770);
		// broadcast write: applied, silent, paced
		cmd(1'b1, 8'h00, 16'd40002, 8'h01, 16'hA5C3, c);
		chk(16'(rq.size()), 16'h0000);
		chk(mem[1], 16'hA5C3);
		chk(16'(c >= 8 + PROC && ok === 1'b1), 16'h0001);
		// locked area write refused
		cmd(1'b1, 8'h05, 16'd41005, 8'h01, 16'h1234, c);
		chk(mem[28], 16'h0BB8);
		chk(16'(drops + 2 * rq.size()), 16'h0001);
		// largest read, then one over the device limit
		cmd(1'b0, 8'h05, 16'd40001, 8'h0A, 16'h0000, c);
		chk({8'h00, rq[2]}, 16'h0014);
		for (int i = 0; i < 10; i++) chk(wq[i], mem[i]);
		chk(16'(rds), 16'h000A);
		cmd(1'b0, 8'h05, 16'd40001, 8'h0B, 16'h0000, c);
		chk(16'(drops + 2 * rq.size()), 16'h0001);
		// foreign address
		cmd(1'b1, 8'h22, 16'd40003, 8'h01, 16'h5555, c);
		chk(16'(drops + 2 * rq.size()), 16'h0001);
		chk(mem[2], 16'h0202);
		// master refuses broadcast read and bad counts
		foreach (bad[i]) begin
			cmd(1'b0, bad[i][15:8], 16'd40001, bad[i][7:0], 16'h0000, c);
			chk(16'(qq.size() + 2 * ok), 16'h0000);
		end
		final_report();
	end
endmodule : tb_modbus_rtu_register_read_write
`default_nettype wire

/* File: src/mrw_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// byte link, one byte per valid cycle, last marks frame end
interface mrw_link_if;
	logic q_valid;
	logic [7:0] q_data;
	logic q_last;
	logic r_valid;
	logic [7:0] r_data;
	logic r_last;
	modport dev (input q_valid, input q_data, input q_last,
		output r_valid, output r_data, output r_last);
	modport mst (output q_valid, output q_data, output q_last,
		input r_valid, input r_data, input r_last);
endinterface : mrw_link_if
`default_nettype wire

/* File: src/mrw_master.sv */
`timescale 1ns/1ps
`default_nettype none
module mrw_master #(
	parameter int PROC_CYC = mrw_pkg::PROC_CYCLES,
	parameter int TIMEOUT_CYC = mrw_pkg::REPLY_TIMEOUT_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	mrw_link_if.mst link,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_slave_i,
	input wire logic [15:0] cmd_reg_num_i,
	input wire logic [7:0] cmd_count_i,
	input wire logic [15:0] cmd_wdata_i,
	output logic rsp_word_valid_o,
	output logic [15:0] rsp_word_o,
	output logic rsp_done_o,
	output logic rsp_ok_o
);
	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_SEND = 4'h2,
		M_RESP = 4'h4,
		M_GAP = 4'h8
	} mrw_mstate_t;

	typedef struct packed {
		mrw_mstate_t st;
		logic [5:0][7:0] frame;
		logic [2:0] idx;
		logic [15:0] crc;
		logic [15:0] timer;
		logic [7:0] rx_idx;
		logic [7:0] exp_last;
		logic fc_ok;
		logic [7:0] hi;
		logic q_valid;
		logic [7:0] q_data;
		logic q_last;
		logic word_valid;
		logic [15:0] word;
		logic done;
		logic ok;
	} mrw_mreg_t;

	mrw_mreg_t m_q, m_d;
	logic [15:0] field;
	logic [15:0] rx_crc;

	assign field = cmd_reg_num_i - mrw_pkg::REG_NUM_BASE; // RULE_03 RULE_08
	assign rx_crc = mrw_pkg::crc_byte(m_q.crc, link.r_data);
	assign cmd_ready_o = (m_q.st == M_IDLE);
	assign link.q_valid = m_q.q_valid;
	assign link.q_data = m_q.q_data;
	assign link.q_last = m_q.q_last;
	assign rsp_word_valid_o = m_q.word_valid;
	assign rsp_word_o = m_q.word;
	assign rsp_done_o = m_q.done;
	assign rsp_ok_o = m_q.ok;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		m_d = m_q;
		m_d.q_valid = 1'b0;
		m_d.q_last = 1'b0;
		m_d.word_valid = 1'b0;
		m_d.done = 1'b0;
		unique case (m_q.st)
			M_IDLE: begin
				if (cmd_valid_i) begin
					if (!cmd_write_i && (cmd_slave_i == mrw_pkg::BCAST_ADDR
						|| cmd_count_i == 8'h00 || cmd_count_i > mrw_pkg::MST_MAX_REGS)) begin
						m_d.done = 1'b1; // RULE_04 RULE_06
						m_d.ok = 1'b0;
					end else begin
						m_d.frame[0] = cmd_slave_i;
						m_d.frame[1] = cmd_write_i ? mrw_pkg::FC_WRITE : mrw_pkg::FC_READ; // RULE_07
						m_d.frame[2] = field[15:8];
						m_d.frame[3] = field[7:0];
						m_d.frame[4] = cmd_write_i ? cmd_wdata_i[15:8] : 8'h00; // RULE_09
						m_d.frame[5] = cmd_write_i ? cmd_wdata_i[7:0] : cmd_count_i;
						m_d.exp_last = cmd_write_i ? 8'h07 : 8'(8'h04 + {cmd_count_i[6:0], 1'b0});
						m_d.idx = 3'h0;
						m_d.crc = mrw_pkg::CRC_INIT;
						m_d.st = M_SEND;
					end
				end
			end
			M_SEND: begin
				m_d.q_valid = 1'b1;
				m_d.idx = m_q.idx + 3'h1;
				if (m_q.idx < 3'h6) begin
					m_d.q_data = m_q.frame[m_q.idx];
					m_d.crc = mrw_pkg::crc_byte(m_q.crc, m_q.frame[m_q.idx]); // RULE_17
				end else if (m_q.idx == 3'h6) begin
					m_d.q_data = m_q.crc[7:0]; // RULE_15
				end else begin
					m_d.q_data = m_q.crc[15:8];
					m_d.q_last = 1'b1;
					m_d.crc = mrw_pkg::CRC_INIT;
					m_d.rx_idx = 8'h00;
					m_d.fc_ok = 1'b0;
					if (m_q.frame[0] == mrw_pkg::BCAST_ADDR) begin
						m_d.timer = 16'(PROC_CYC); // RULE_13
						m_d.st = M_GAP;
					end else begin
						m_d.timer = 16'(TIMEOUT_CYC);
						m_d.st = M_RESP;
					end
				end
			end
			M_RESP: begin
				m_d.timer = m_q.timer - 16'h0001;
				if (link.r_valid) begin
					m_d.crc = rx_crc;
					m_d.rx_idx = m_q.rx_idx + 8'h01;
					if (m_q.rx_idx == 8'h01) begin
						m_d.fc_ok = (link.r_data == m_q.frame[1]);
					end
					// read data pairs high then low from byte three
					if (m_q.frame[1] == mrw_pkg::FC_READ && m_q.rx_idx >= 8'h03
						&& m_q.rx_idx < m_q.exp_last - 8'h01) begin
						if (m_q.rx_idx[0]) begin
							m_d.hi = link.r_data; // RULE_01
						end else begin
							m_d.word = {m_q.hi, link.r_data};
							m_d.word_valid = 1'b1;
						end
					end
					if (link.r_last) begin
						m_d.done = 1'b1;
						m_d.ok = (rx_crc == mrw_pkg::CRC_RESIDUE) && m_q.fc_ok
							&& (m_q.rx_idx == m_q.exp_last); // RULE_15
						m_d.st = M_IDLE;
					end
				end else if (m_q.timer == 16'h0000) begin
					m_d.done = 1'b1;
					m_d.ok = 1'b0;
					m_d.st = M_IDLE;
				end
			end
			M_GAP: begin
				m_d.timer = m_q.timer - 16'h0001;
				if (m_q.timer == 16'h0000) begin
					m_d.done = 1'b1; // RULE_13
					m_d.ok = 1'b1;
					m_d.st = M_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			m_q <= '0;
			m_q.st <= M_IDLE;
			m_q.crc <= mrw_pkg::CRC_INIT;
		end else begin
			m_q <= m_d;
		end
	end
endmodule : mrw_master
`default_nettype wire

/* File: src/mrw_pkg.sv */
// Notes on behaviour
// [RULE_01] read data goes out high byte first
// [RULE_02] read values follow consecutive addresses upward
// [RULE_03] read start field is register number minus 40001
// [RULE_04] master asks at most 125 registers
// [RULE_05] byte count equals twice count, 2..20
// [RULE_06] master never broadcasts a read
// [RULE_07] write query: address, 06, register, data, CRC
// [RULE_08] write address field is number minus 40001
// [RULE_09] write value is two bytes, high first
// [RULE_10] broadcast write is accepted and applied
// [RULE_11] addressed write echoes the query including CRC
// [RULE_12] no reply to any broadcast query
// [RULE_13] master waits processing time after broadcast
// [RULE_14] writes only to permitted register areas
// [RULE_15] frames end in CRC, low byte first
// [RULE_16] foreign slave addresses are silently dropped
// [RULE_17] check value is standard Modbus CRC-16
package mrw_pkg;
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h06;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [2:0] QUERY_LAST = 3'h7;
	localparam logic [7:0] DEV_MAX_REGS = 8'h0A;
	localparam logic [7:0] MST_MAX_REGS = 8'h7D;
	localparam logic [15:0] REG_NUM_BASE = 16'h9C41;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROC_TIME_NS = 1000;
	localparam int PROC_CYCLES = (PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPLY_TIMEOUT_NS = 100000;
	localparam int REPLY_TIMEOUT_CYCLES = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// reflected crc-16 update, one byte
	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1); // RULE_17
		end
		return c;
	endfunction : crc_byte
endpackage : mrw_pkg

/* File: src/mrw_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module mrw_slave (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	mrw_link_if.dev link,
	input wire logic [7:0] own_addr_i,
	output logic reg_rd_o,
	output logic reg_wr_o,
	output logic [15:0] reg_addr_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [15:0] reg_rdata_i,
	input wire logic reg_wr_allow_i,
	output logic drop_o
);
	// one-hot states of the device end
	typedef enum logic [8:0] {
		S_RX = 9'h001,
		S_SKIP = 9'h002,
		S_EVAL = 9'h004,
		S_ECHO = 9'h008,
		S_RHDR = 9'h010,
		S_RDREQ = 9'h020,
		S_RHI = 9'h040,
		S_RLO = 9'h080,
		S_RCRC = 9'h100
	} mrw_sstate_t;

	// whole state of the device end in one word
	typedef struct packed {
		mrw_sstate_t st;
		logic [7:0][7:0] frame;
		logic [2:0] idx;
		logic [15:0] crc;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [7:0] rem;
		logic [7:0] lo;
		logic r_valid;
		logic [7:0] r_data;
		logic r_last;
		logic drop;
	} mrw_sreg_t;

	// registered state, next state and decoded query fields
	mrw_sreg_t s_q, s_d;
	logic crc_good;
	logic addr_hit;
	logic is_bcast;
	logic [15:0] count;

	////////////////////////////////////////////////////////////////////////////////
	// decode of the received query
	assign crc_good = (s_q.crc == mrw_pkg::CRC_RESIDUE); // RULE_15
	assign is_bcast = (s_q.frame[0] == mrw_pkg::BCAST_ADDR);
	assign addr_hit = (s_q.frame[0] == own_addr_i) || is_bcast; // RULE_16
	assign count = {s_q.frame[4], s_q.frame[5]};

	// strobes toward the register map
	assign reg_rd_o = (s_q.st == S_RDREQ);
	assign reg_wr_o = (s_q.st == S_EVAL) && crc_good && addr_hit
		&& (s_q.frame[1] == mrw_pkg::FC_WRITE) && reg_wr_allow_i; // RULE_10 RULE_14
	assign reg_addr_o = s_q.addr;
	assign reg_wdata_o = s_q.wdata;
	assign link.r_valid = s_q.r_valid;
	assign link.r_data = s_q.r_data;
	assign link.r_last = s_q.r_last;
	assign drop_o = s_q.drop;

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_d = s_q;
		s_d.r_valid = 1'b0;
		s_d.r_last = 1'b0;
		s_d.drop = 1'b0;
		unique case (s_q.st)
			// collect query bytes, crc runs along with them
			S_RX: begin
				if (link.q_valid) begin
					s_d.frame[s_q.idx] = link.q_data;
					s_d.crc = mrw_pkg::crc_byte(s_q.crc, link.q_data); // RULE_15
					s_d.idx = s_q.idx + 3'h1;
					if (s_q.idx == 3'h3) begin
						s_d.addr = {s_q.frame[2], link.q_data}; // RULE_03 RULE_08
					end
					if (s_q.idx == 3'h5) begin
						s_d.wdata = {s_q.frame[4], link.q_data}; // RULE_09
					end
					if (link.q_last) begin
						if (s_q.idx == mrw_pkg::QUERY_LAST) begin
							s_d.st = S_EVAL;
						end else begin
							s_d.idx = 3'h0;
							s_d.crc = mrw_pkg::CRC_INIT;
							s_d.drop = 1'b1;
						end
					end else if (s_q.idx == mrw_pkg::QUERY_LAST) begin
						s_d.st = S_SKIP; // frame too long
					end
				end
			end
			// overlong frame, wait for its end and throw it away
			S_SKIP: begin
				if (link.q_valid && link.q_last) begin
					s_d.st = S_RX;
					s_d.idx = 3'h0;
					s_d.crc = mrw_pkg::CRC_INIT;
					s_d.drop = 1'b1;
				end
			end
			// judge the held frame, anything refused only pulses drop
			S_EVAL: begin
				s_d.st = S_RX;
				s_d.idx = 3'h0;
				s_d.crc = mrw_pkg::CRC_INIT;
				s_d.drop = 1'b1;
				if (crc_good && addr_hit) begin
					if (s_q.frame[1] == mrw_pkg::FC_READ) begin
						// broadcast read is refused, length bounded
						if (!is_bcast && count != 16'h0000
							&& count <= {8'h00, mrw_pkg::DEV_MAX_REGS}) begin // RULE_05 RULE_12
							s_d.st = S_RHDR;
							s_d.rem = count[7:0];
							s_d.drop = 1'b0;
						end
					end else if (s_q.frame[1] == mrw_pkg::FC_WRITE && reg_wr_allow_i) begin
						// write applied this cycle, broadcast stays silent
						s_d.drop = 1'b0;
						if (!is_bcast) begin
							s_d.st = S_ECHO; // RULE_12
						end
					end
				end
			end
			// replay the eight stored bytes, crc included
			S_ECHO: begin
				s_d.r_valid = 1'b1;
				s_d.r_data = s_q.frame[s_q.idx]; // RULE_11
				s_d.r_last = (s_q.idx == mrw_pkg::QUERY_LAST);
				s_d.idx = s_q.idx + 3'h1;
				if (s_q.idx == mrw_pkg::QUERY_LAST) begin
					s_d.st = S_RX;
				end
			end
			// address, function and byte count of the read reply
			S_RHDR: begin
				s_d.r_valid = 1'b1;
				s_d.idx = s_q.idx + 3'h1;
				if (s_q.idx == 3'h0) begin
					s_d.r_data = s_q.frame[0];
				end else if (s_q.idx == 3'h1) begin
					s_d.r_data = mrw_pkg::FC_READ;
				end else begin
					s_d.r_data = {s_q.rem[6:0], 1'b0}; // RULE_05
					s_d.st = S_RDREQ;
				end
				s_d.crc = mrw_pkg::crc_byte(s_q.crc, s_d.r_data);
			end
			// read strobe, the map answers in the next cycle
			S_RDREQ: begin
				s_d.st = S_RHI;
			end
			// high byte goes out, low byte kept for the next cycle
			S_RHI: begin
				s_d.r_valid = 1'b1;
				s_d.r_data = reg_rdata_i[15:8]; // RULE_01
				s_d.lo = reg_rdata_i[7:0];
				s_d.crc = mrw_pkg::crc_byte(s_q.crc, reg_rdata_i[15:8]);
				s_d.st = S_RLO;
			end
			// low byte goes out, step to the next address
			S_RLO: begin
				s_d.r_valid = 1'b1;
				s_d.r_data = s_q.lo; // RULE_01
				s_d.crc = mrw_pkg::crc_byte(s_q.crc, s_q.lo);
				s_d.addr = s_q.addr + 16'h0001; // RULE_02
				s_d.rem = s_q.rem - 8'h01;
				s_d.idx = 3'h0;
				s_d.st = (s_q.rem == 8'h01) ? S_RCRC : S_RDREQ; // RULE_02
			end
			// check value of the reply, low byte first
			S_RCRC: begin
				s_d.r_valid = 1'b1;
				s_d.idx = s_q.idx + 3'h1;
				if (s_q.idx == 3'h0) begin
					s_d.r_data = s_q.crc[7:0]; // RULE_15
				end else begin
					s_d.r_data = s_q.crc[15:8];
					s_d.r_last = 1'b1;
					s_d.st = S_RX;
					s_d.idx = 3'h0;
					s_d.crc = mrw_pkg::CRC_INIT;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			// clear all, then idle state and crc seed
			s_q <= '0;
			s_q.st <= S_RX;
			s_q.crc <= mrw_pkg::CRC_INIT;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : mrw_slave
`default_nettype wire
